// [verilog/ctap_pkg.sv]
/*
 Package for the cache RAM test access port: widths, select bit positions,
 slice widths and carrier structs.
 Assumes a single clock domain shared with the cache controller.
*/
package ctap_pkg;
   // ********************************************************************
   // Widths
   // ********************************************************************
   localparam int ADDR_W     = 18;
   localparam int DATA_W     = 64;
   localparam int CE_W       = 11;
   localparam int SEL_W      = 13;
   localparam int NUM_TAGS   = 8;
   localparam int PAR_W      = 32;
   localparam int TAG_W      = 20;
   localparam int DIRTY_W    = 16;
   localparam int LINE_W     = 256;
   localparam int DATA_IDX_W = 16;
   localparam int PAR_IDX_W  = 16;
   localparam int TAG_IDX_W  = 13;
   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int CE_DATA     = 0;
   localparam int CE_TAG0     = 1;
   localparam int CE_DIRTY    = 9;
   localparam int CE_PARITY   = 10;
   localparam int SEL_SLICE_L = 0;
   localparam int SEL_DATA    = 2;
   localparam int SEL_TAG0    = 3;
   localparam int SEL_PARITY  = 11;
   localparam int SEL_DIRTY   = 12;
   localparam int ADDR_IDX_L  = 2;
   localparam int ADDR_TAG_H  = 14;
   // ********************************************************************
   // Reset values
   // ********************************************************************
   localparam logic [63:0] RST_READ_DATA = 64'h0000_0000_0000_0000;

   // Request from the self-test controller
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic [CE_W-1:0]   writeEnables;
      logic [SEL_W-1:0]  readSelect;
      logic [DATA_W-1:0] writeData;
      logic              writeStrobe;
      logic              testModeOn;
   } ctap_req_type;

   // Per-RAM raw read data from the cache RAMs
   typedef struct packed {
      logic [LINE_W-1:0]           dataLine;
      logic [PAR_W-1:0]            parity;
      logic [NUM_TAGS*TAG_W-1:0]   tags;
      logic [DIRTY_W-1:0]          dirty;
   } ctap_rd_type;

   // Test-side RAM drive: one write and chip select per RAM
   typedef struct packed {
      logic                        active;
      logic [DATA_IDX_W-1:0]       dataIndex;
      logic [1:0]                  dataWord;
      logic [PAR_IDX_W-1:0]        parityIndex;
      logic [TAG_IDX_W-1:0]        tagIndex;
      logic [CE_W-1:0]             ramSelect;
      logic [CE_W-1:0]             ramWrite;
      logic [DATA_W-1:0]           writeData;
   } ctap_ram_type;
endpackage

// [verilog/ctap_port.sv]
/*
 Cache RAM test access port: maps self-test controller requests onto the
 cache RAM ports and returns the selected RAM's read data.
 Assumes the test controller runs on core_clk; the RAM muxes downstream
 honour ramDrive.active as the test-over-normal override.
*/
`timescale 1ns/10ps
module ctap_port (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   reset_n,
   // Self-test controller side
   input  wire ctap_pkg::ctap_req_type testReq,
   output logic [ctap_pkg::DATA_W-1:0] testReadData,
   // Cache RAM side
   input  wire ctap_pkg::ctap_rd_type  ramRead,
   output ctap_pkg::ctap_ram_type      ramDrive
);
   // ********************************************************************
   // Read slice selection
   // ********************************************************************
   // Priority data, tags, parity, dirty; several selects at once is a
   // controller fault, and priority keeps the result deterministic.
   function automatic logic [63:0] pickRead(input ctap_pkg::ctap_req_type r,
                                            input ctap_pkg::ctap_rd_type d);
      logic [63:0] res;
      res = 64'h0000_0000_0000_0000;
      if (r.readSelect[ctap_pkg::SEL_DATA]) begin
         res = d.dataLine[r.readSelect[1:0]*64 +: 64];
      end else if (|r.readSelect[ctap_pkg::SEL_TAG0 +: ctap_pkg::NUM_TAGS]) begin
         for (int i = ctap_pkg::NUM_TAGS-1; i >= 0; i--) begin
            if (r.readSelect[ctap_pkg::SEL_TAG0+i]) begin
               res = {44'h000_0000_0000, d.tags[i*ctap_pkg::TAG_W +: ctap_pkg::TAG_W]};
            end
         end
      end else if (r.readSelect[ctap_pkg::SEL_PARITY]) begin
         res = {32'h0000_0000, d.parity};
      end else if (r.readSelect[ctap_pkg::SEL_DIRTY]) begin
         res = {48'h0000_0000_0000, d.dirty};
      end
      return res;
   endfunction

   logic [63:0]              readData_d;
   logic [63:0]              readData_q;
   ctap_pkg::ctap_ram_type   drive_d;
   ctap_pkg::ctap_ram_type   drive_q;

   // ********************************************************************
   // Next values
   // ********************************************************************
   // Read data registered one cycle after the RAM data is presented
   always_comb begin
      readData_d = testReq.testModeOn ? pickRead(testReq, ramRead) : ctap_pkg::RST_READ_DATA;
      drive_d = '0;
      drive_d.active      = testReq.testModeOn;
      drive_d.dataIndex   = testReq.address[ctap_pkg::ADDR_W-1:ctap_pkg::ADDR_IDX_L];
      drive_d.dataWord    = testReq.address[1:0];
      drive_d.parityIndex = testReq.address[ctap_pkg::ADDR_W-1:ctap_pkg::ADDR_IDX_L];
      drive_d.tagIndex    = testReq.address[ctap_pkg::ADDR_TAG_H:ctap_pkg::ADDR_IDX_L];
      drive_d.writeData   = testReq.writeData;
      if (testReq.testModeOn) begin
         // Chip selects for reads come from read select, writes from enables
         drive_d.ramSelect[ctap_pkg::CE_DATA]   = testReq.readSelect[ctap_pkg::SEL_DATA];
         drive_d.ramSelect[ctap_pkg::CE_TAG0 +: ctap_pkg::NUM_TAGS] =
            testReq.readSelect[ctap_pkg::SEL_TAG0 +: ctap_pkg::NUM_TAGS];
         drive_d.ramSelect[ctap_pkg::CE_DIRTY]  = testReq.readSelect[ctap_pkg::SEL_DIRTY];
         drive_d.ramSelect[ctap_pkg::CE_PARITY] = testReq.readSelect[ctap_pkg::SEL_PARITY];
         if (testReq.writeStrobe) begin
            drive_d.ramWrite  = testReq.writeEnables;
            drive_d.ramSelect = drive_d.ramSelect | testReq.writeEnables;
         end
      end
   end

   // ********************************************************************
   // Registers
   // ********************************************************************
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         readData_q <= ctap_pkg::RST_READ_DATA;
         drive_q    <= '0;
      end else begin
         readData_q <= readData_d;
         drive_q    <= drive_d;
      end
   end

   assign testReadData = readData_q;
   assign ramDrive     = drive_q;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   property p_dataRead;
      @(posedge core_clk) disable iff (!reset_n)
      (testReq.testModeOn && testReq.readSelect[2]) |=>
         testReadData == $past(ramRead.dataLine[testReq.readSelect[1:0]*64 +: 64]);
   endproperty
   a_dataRead: assert property (p_dataRead) else $error("data slice wrong");

   property p_parityRead;
      @(posedge core_clk) disable iff (!reset_n)
      (testReq.testModeOn && testReq.readSelect[12:2] == 11'h200) |=>
         testReadData == {32'h0000_0000, $past(ramRead.parity)};
   endproperty
   a_parityRead: assert property (p_parityRead) else $error("parity read wrong");

   property p_dirtyRead;
      @(posedge core_clk) disable iff (!reset_n)
      (testReq.testModeOn && testReq.readSelect[12:2] == 11'h400) |=>
         testReadData == {48'h0000_0000_0000, $past(ramRead.dirty)};
   endproperty
   a_dirtyRead: assert property (p_dirtyRead) else $error("dirty read wrong");

   property p_tag0Read;
      @(posedge core_clk) disable iff (!reset_n)
      (testReq.testModeOn && testReq.readSelect[12:2] == 11'h002) |=>
         testReadData == {44'h000_0000_0000, $past(ramRead.tags[19:0])};
   endproperty
   a_tag0Read: assert property (p_tag0Read) else $error("tag 0 read wrong");

   property p_tag7Read;
      @(posedge core_clk) disable iff (!reset_n)
      (testReq.testModeOn && testReq.readSelect[12:2] == 11'h100) |=>
         testReadData == {44'h000_0000_0000, $past(ramRead.tags[159:140])};
   endproperty
   a_tag7Read: assert property (p_tag7Read) else $error("tag 7 read wrong");

   property p_parityIndex;
      @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> ramDrive.parityIndex == $past(testReq.address[17:2]);
   endproperty
   a_parityIndex: assert property (p_parityIndex) else $error("parity index wrong");

   property p_tagIndex;
      @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> ramDrive.tagIndex == $past(testReq.address[14:2]);
   endproperty
   a_tagIndex: assert property (p_tagIndex) else $error("tag index wrong");

   property p_writeMap;
      @(posedge core_clk) disable iff (!reset_n)
      (testReq.testModeOn && testReq.writeStrobe) |=>
         ramDrive.ramWrite == $past(testReq.writeEnables) && ramDrive.active;
   endproperty
   a_writeMap: assert property (p_writeMap) else $error("write enables lost");

   property p_noTestWrite;
      @(posedge core_clk) disable iff (!reset_n)
      !(testReq.testModeOn && testReq.writeStrobe) |=> ramDrive.ramWrite == 11'h000;
   endproperty
   a_noTestWrite: assert property (p_noTestWrite) else $error("stray write");

   // Mode off hands the RAMs back and parks the read bus at zero
   property p_modeOffRead;
      @(posedge core_clk) disable iff (!reset_n)
      !testReq.testModeOn |=> testReadData == ctap_pkg::RST_READ_DATA;
   endproperty
   a_modeOffRead: assert property (p_modeOffRead) else $error("read data not parked");

   property p_modeOffIdle;
      @(posedge core_clk) disable iff (!reset_n)
      !testReq.testModeOn |=> !ramDrive.active && ramDrive.ramSelect == 11'h000;
   endproperty
   a_modeOffIdle: assert property (p_modeOffIdle) else $error("drive while off");

   property p_modeOnActive;
      @(posedge core_clk) disable iff (!reset_n)
      testReq.testModeOn |=> ramDrive.active;
   endproperty
   a_modeOnActive: assert property (p_modeOnActive) else $error("override missing");

   property p_dataIndex;
      @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> ramDrive.dataIndex == $past(testReq.address[17:2]) &&
               ramDrive.dataWord == $past(testReq.address[1:0]);
   endproperty
   a_dataIndex: assert property (p_dataIndex) else $error("data index wrong");

   property p_writeData;
      @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> ramDrive.writeData == $past(testReq.writeData);
   endproperty
   a_writeData: assert property (p_writeData) else $error("write data lost");

   property p_writeSelect;
      @(posedge core_clk) disable iff (!reset_n)
      (testReq.testModeOn && testReq.writeStrobe) |=>
         (ramDrive.ramSelect & $past(testReq.writeEnables)) == $past(testReq.writeEnables);
   endproperty
   a_writeSelect: assert property (p_writeSelect) else $error("write select lost");

   // Read chip selects follow the write enable order of the RAMs
   property p_readSelectMap;
      @(posedge core_clk) disable iff (!reset_n)
      (testReq.testModeOn && !testReq.writeStrobe) |=>
         ramDrive.ramSelect == {$past(testReq.readSelect[11]), $past(testReq.readSelect[12]),
                                $past(testReq.readSelect[10:3]), $past(testReq.readSelect[2])};
   endproperty
   a_readSelectMap: assert property (p_readSelectMap) else $error("read select map");

   property p_tagUpperZero;
      @(posedge core_clk) disable iff (!reset_n)
      (testReq.testModeOn && !testReq.readSelect[2] && |testReq.readSelect[10:3]) |=>
         testReadData[63:20] == 44'h000_0000_0000;
   endproperty
   a_tagUpperZero: assert property (p_tagUpperZero) else $error("tag upper bits set");

   property p_noSourceZero;
      @(posedge core_clk) disable iff (!reset_n)
      (testReq.testModeOn && testReq.readSelect[12:2] == 11'h000) |=>
         testReadData == 64'h0000_0000_0000_0000;
   endproperty
   a_noSourceZero: assert property (p_noSourceZero) else $error("read without source");
endmodule

// [dv/ctap_ctl_model.sv]
/*
 Self-test controller model: issues one test request per call.
 Assumes the bench owns core_clk and calls issue from its scenarios.
*/
`timescale 1ns/10ps
module ctap_ctl_model (
   // Clock
   input  wire logic              core_clk,
   // Request to the port
   output ctap_pkg::ctap_req_type testReq
);
   // Quiet request until the first call
   initial testReq = '0;

   // Changes just after an edge and holds until the next call
   task automatic issue(input logic [17:0] a, input logic [10:0] ce, input logic [12:0] sel,
                        input logic [63:0] wd, input logic we, input logic on);
      @(posedge core_clk);
      testReq.address      <= a;
      testReq.writeEnables <= ce;
      testReq.readSelect   <= sel;
      testReq.writeData    <= wd;
      testReq.writeStrobe  <= we;
      testReq.testModeOn   <= on;
   endtask
endmodule

// [dv/tb.sv]
/*
 Bench for the cache RAM test access port: reads, writes, mode off.
 Assumes fixed RAM read patterns held by the bench on ramRead.
*/
`timescale 1ns/10ps
module tb;
   logic                   core_clk;
   logic                   reset_n;
   ctap_pkg::ctap_req_type testReq;
   ctap_pkg::ctap_rd_type  ramRead;
   ctap_pkg::ctap_ram_type ramDrive;
   logic [63:0]            testReadData;
   int                     failures;
   int                     totalChecks;
   // ***************************************************************
   // Clock and fixed RAM contents
   // ***************************************************************
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // Distinct slices so a wrong pick cannot match
   initial begin
      ramRead.dataLine = {64'h4444_0404_4444_0404, 64'h3333_0303_3333_0303,
                          64'h2222_0202_2222_0202, 64'h1111_0101_1111_0101};
      ramRead.parity = 32'h5a5a_c3c3;
      ramRead.dirty = 16'hbeef;
      for (int i = 0; i < 8; i++) begin
         ramRead.tags[i*20+:20] = 20'h9_c000 + 20'(i);
      end
   end
   ctap_port dut (.core_clk(core_clk), .reset_n(reset_n), .testReq(testReq),
                  .testReadData(testReadData), .ramRead(ramRead), .ramDrive(ramDrive));
   ctap_ctl_model ctl (.core_clk(core_clk), .testReq(testReq));
   // ***************************************************************
   // Helpers
   // ***************************************************************
   task automatic chk(input logic ok, input string msg);
      totalChecks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   // Answer is registered on the edge after the request is driven
   task automatic req(input logic [17:0] a, input logic [10:0] ce, input logic [12:0] sel,
                      input logic [63:0] wd, input logic we, input logic on);
      ctl.issue(a, ce, sel, wd, we, on);
      @(posedge core_clk);
      #1;
   endtask
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_data;
      logic [17:0] a;
      for (int s = 0; s < 4; s++) begin
         a = {16'ha5c3, 2'(s)};
         req(a, 11'h0, 13'h004 | 13'(s), 64'h0, 1'b0, 1'b1);
         chk(testReadData === ramRead.dataLine[s*64+:64], "data slice");
         chk(ramDrive.dataIndex === a[17:2] && ramDrive.dataWord === a[1:0], "data idx");
         chk(ramDrive.ramSelect === 11'h001, "data select");
      end
   endtask
   task automatic t_narrow;
      logic [17:0] a;
      a = 18'h2_b7d6;
      for (int i = 0; i < 8; i++) begin
         req(a, 11'h0, 13'h008 << i, 64'h0, 1'b0, 1'b1);
         chk(testReadData === {44'h0, ramRead.tags[i*20+:20]}, "tag read");
         chk(ramDrive.tagIndex === a[14:2], "tag index");
         chk(ramDrive.ramSelect === (11'h002 << i), "tag select");
      end
      req(a, 11'h0, 13'h0800, 64'h0, 1'b0, 1'b1);
      chk(testReadData === {32'h0, ramRead.parity}, "parity read");
      chk(ramDrive.parityIndex === a[17:2], "parity index");
      chk(ramDrive.ramSelect === 11'h400, "parity select");
      req(a, 11'h0, 13'h1000, 64'h0, 1'b0, 1'b1);
      chk(testReadData === {48'h0, ramRead.dirty}, "dirty read");
      chk(ramDrive.ramSelect === 11'h200, "dirty select");
      chk(ramDrive.tagIndex === a[14:2], "dirty index");
   endtask
   task automatic t_write;
      logic [63:0] wd;
      for (int b = 0; b < 11; b++) begin
         wd = 64'hf00d_0000_0000_0000 + 64'(b);
         req(18'h1_0004, 11'h1 << b, 13'h0, wd, 1'b1, 1'b1);
         chk(ramDrive.ramWrite === (11'h1 << b), "wr en");
         chk(ramDrive.ramSelect === (11'h1 << b), "wr select");
         chk(ramDrive.writeData === wd && ramDrive.active === 1'b1, "write data");
      end
   endtask
   // Neither mode off nor a missing strobe may write
   task automatic t_off;
      req(18'h0, 11'h7ff, 13'h004, 64'h1, 1'b1, 1'b0);
      chk(testReadData === 64'h0 && ramDrive.ramWrite === 11'h0, "mode off");
      chk(ramDrive.active === 1'b0 && ramDrive.ramSelect === 11'h0, "off select");
      req(18'h0, 11'h7ff, 13'h0, 64'h1, 1'b0, 1'b1);
      chk(ramDrive.ramWrite === 11'h0, "no strobe");
      chk(testReadData === 64'h0 && ramDrive.ramSelect === 11'h0, "no source");
   endtask
   // Mid-run reset from a busy port; request is quiet again before release
   task automatic t_reset;
      req(18'h3_ffff, 11'h7ff, 13'h004, 64'h1, 1'b1, 1'b1);
      ctl.issue(18'h0, 11'h0, 13'h0, 64'h0, 1'b0, 1'b0);
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk(testReadData === 64'h0 && ramDrive === '0, "mid-run reset");
      @(posedge core_clk);
      reset_n <= 1'b1;
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      failures = 0;
      totalChecks = 0;
      reset_n = 1'b0;
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      #1;
      chk(testReadData === 64'h0 && ramDrive.ramWrite === 11'h0, "reset value");
      t_data();
      t_narrow();
      t_write();
      t_reset();
      t_off();
      finish_test();
   end
endmodule
